// file: verilog/agu_pkg.sv
// shared constants and carrier types for operand decode and address generation
package agu_pkg;

  localparam int ADDR_W       = 16;
  localparam int DATA_W       = 16;
  localparam int ACC_W        = 36;
  localparam int EXT_W        = 4;
  localparam int SHORT_ADDR_W = 6;
  localparam int IMM_MOVE_W   = 7;
  localparam int IMM_LOOP_W   = 6;
  localparam int MASK_W       = 8;
  localparam int DISP_W       = 7;
  localparam int NUM_PTR      = 4;

  localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] SP_RESET  = 16'h0000;
  localparam logic [ADDR_W-1:0] OFS_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] MOD_RESET = 16'hffff;
  localparam logic [ADDR_W-1:0] MOD_LINEAR = 16'hffff;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [EXT_W-1:0]  EXT_RESET  = 4'h0;

  // combined arithmetic operand field: accumulator a/b or data register
  localparam logic [2:0] FDD_ACC_A   = 3'h0;
  localparam logic [2:0] FDD_ACC_B   = 3'h1;
  localparam logic [2:0] FDD_X       = 3'h4;
  localparam logic [2:0] FDD_Y_LOW   = 3'h5;
  localparam logic [2:0] FDD_Y_HIGH  = 3'h6;

  // data register field
  localparam logic [1:0] DD_X        = 2'h0;
  localparam logic [1:0] DD_Y_LOW    = 2'h1;
  localparam logic [1:0] DD_Y_HIGH   = 2'h2;

  // pointer select: 0..3 pointers, 4 stack pointer
  localparam logic [2:0] PSEL_SP     = 3'h4;

  typedef enum logic [2:0] {
    AM_POST_NONE, AM_POST_INC, AM_POST_DEC, AM_POST_OFS, AM_IDX_OFS, AM_IDX_DISP
  } addr_mode_type;

  typedef enum logic [2:0] {
    OP_ABS_LONG, OP_PERIPH_SHORT, OP_ABS_SHORT, OP_IMM_MOVE, OP_IMM_LOOP,
    OP_MASK_HIGH, OP_MASK_LOW
  } operand_kind_type;

  typedef enum logic [2:0] {
    WR_NONE, WR_ACC_WHOLE, WR_ACC_EXT, WR_ACC_UPPER, WR_ACC_LOWER, WR_DATA,
    WR_PTR, WR_AGU_CTRL
  } wr_kind_type;

  typedef struct packed {
    logic [EXT_W-1:0]  extension_portion;
    logic [DATA_W-1:0] upper_portion;
    logic [DATA_W-1:0] lower_portion;
  } accum_type;

  typedef struct packed {
    logic          valid;
    addr_mode_type mode;
    logic [2:0]    ptr_sel;
    logic          to_program;
    logic [ADDR_W-1:0] disp;
  } ea_req_type;

endpackage : agu_pkg

// file: verilog/pointer_update.sv
// next-value arithmetic for one pointer: linear or modulo
`timescale 1ns/1ps
`default_nettype none
module pointer_update (
  input  wire logic [15:0] i_ptr,
  input  wire logic [15:0] i_step,
  input  wire logic        i_modulo_en,
  input  wire logic [15:0] i_modulo_size,
  output logic      [15:0] o_ptr_next
);
  import agu_pkg::*;

  logic [ADDR_W-1:0] linear_sum;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] offs;
  logic [ADDR_W-1:0] wrapped;

  always_comb begin
    linear_sum = i_ptr + i_step;
    base       = i_ptr - (i_ptr % i_modulo_size);
    offs       = ADDR_W'((32'(i_ptr % i_modulo_size) + 32'(i_step) + 32'(i_modulo_size)
                 - 32'h0001_0000 * 32'(i_step[15])) % 32'(i_modulo_size));
    wrapped    = base + offs;
    // modulo keeps the pointer inside its aligned buffer
    o_ptr_next = (i_modulo_en && i_modulo_size != 16'h0000) ? wrapped : linear_sum;
  end
endmodule : pointer_update
`default_nettype wire

// file: verilog/operand_extend.sv
// widening of short address, immediate, mask and displacement operands
`timescale 1ns/1ps
`default_nettype none
module operand_extend (
  input  wire logic                     [15:0] i_ext_word,
  input  wire logic                     [15:0] i_instr,
  input  wire agu_pkg::operand_kind_type       i_kind,
  input  wire logic                     [15:0] i_pc,
  output logic                          [15:0] o_operand,
  output logic                          [15:0] o_branch_target
);
  import agu_pkg::*;

  logic [SHORT_ADDR_W-1:0] short_addr;
  logic [MASK_W-1:0]       mask;
  logic [DISP_W-1:0]       branch_disp;

  always_comb begin
    short_addr  = i_instr[SHORT_ADDR_W-1:0];
    mask        = i_instr[MASK_W-1:0];
    branch_disp = i_instr[DISP_W-1:0];
    case (i_kind)
      OP_ABS_LONG:     o_operand = i_ext_word;
      OP_PERIPH_SHORT: o_operand = {{(ADDR_W-SHORT_ADDR_W){1'b1}}, short_addr};
      OP_ABS_SHORT:    o_operand = {{(ADDR_W-SHORT_ADDR_W){1'b0}}, short_addr};
      OP_IMM_MOVE:     o_operand = {{(DATA_W-IMM_MOVE_W){i_instr[IMM_MOVE_W-1]}},
                                    i_instr[IMM_MOVE_W-1:0]};
      OP_IMM_LOOP:     o_operand = {{(DATA_W-IMM_LOOP_W){1'b0}}, i_instr[IMM_LOOP_W-1:0]};
      OP_MASK_HIGH:    o_operand = {mask, {MASK_W{1'b0}}};
      OP_MASK_LOW:     o_operand = {{MASK_W{1'b0}}, mask};
      default:         o_operand = i_ext_word;
    endcase
    o_branch_target = i_pc + {{(ADDR_W-DISP_W){branch_disp[DISP_W-1]}}, branch_disp};
  end
endmodule : operand_extend
`default_nettype wire

// file: verilog/dsp_operand_address_generation.sv
// operand field decode, register file and address generation for the core
`timescale 1ns/1ps
`default_nettype none
module dsp_operand_address_generation #(
  parameter logic [15:0] MOD_LINEAR_CODE = agu_pkg::MOD_LINEAR,
  parameter bit          MOD_COVERS_ONE  = 1'b1
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire logic              [2:0] i_alu_operand_field,
  input  wire logic              [2:0] i_alu_upper_operand_field,
  input  wire logic                    i_accum_field,
  input  wire logic                    i_accum_upper_field,
  input  wire logic              [1:0] i_data_reg_field,
  input  wire agu_pkg::wr_kind_type    i_wr_kind,
  input  wire logic              [2:0] i_wr_sel,
  input  wire logic             [35:0] i_wr_data,
  input  wire agu_pkg::ea_req_type     i_ea_req,
  input  wire agu_pkg::ea_req_type     i_ea_req2,
  input  wire logic             [15:0] i_ext_word,
  input  wire logic             [15:0] i_instr,
  input  wire agu_pkg::operand_kind_type i_operand_kind,
  input  wire logic             [15:0] i_pc,
  output logic                  [35:0] o_alu_operand,
  output logic                  [15:0] o_alu_upper_operand,
  output logic                  [35:0] o_accum_operand,
  output logic                  [15:0] o_accum_upper_operand,
  output logic                  [15:0] o_data_reg_operand,
  output logic                  [15:0] o_operand,
  output logic                  [15:0] o_branch_target,
  output logic                  [15:0] o_effective_addr,
  output logic                         o_addr_valid,
  output logic                         o_addr_program,
  output logic                  [15:0] o_effective_addr2,
  output logic                         o_addr2_valid,
  output logic                  [15:0] o_pointer_zero,
  output logic                  [15:0] o_pointer_one,
  output logic                  [15:0] o_pointer_two,
  output logic                  [15:0] o_pointer_three,
  output logic                  [15:0] o_stack_ptr,
  output logic                  [15:0] o_offset,
  output logic                  [15:0] o_modifier_reg
);
  import agu_pkg::*;

  accum_type         accum_reg [2];
  logic [DATA_W-1:0] data_reg [3];
  logic [ADDR_W-1:0] pointer_reg [NUM_PTR];
  logic [ADDR_W-1:0] stack_ptr_reg;
  logic [ADDR_W-1:0] offset_reg;
  logic [ADDR_W-1:0] modifier_reg;

  logic [ADDR_W-1:0] ea_next;
  logic              ea_valid_next;
  logic              ea_prog_next;
  logic [ADDR_W-1:0] ea2_next;
  logic              ea2_valid_next;
  logic [ADDR_W-1:0] ea_reg;
  logic              ea_valid_reg;
  logic              ea_prog_reg;
  logic [ADDR_W-1:0] ea2_reg;
  logic              ea2_valid_reg;
  logic [ADDR_W-1:0] sel_ptr;
  logic [ADDR_W-1:0] step;
  logic              do_update;
  logic [ADDR_W-1:0] upd_result [NUM_PTR+1];
  logic              modulo_en [NUM_PTR+1];
  logic [ADDR_W-1:0] ptr2_next;
  logic [ADDR_W-1:0] operand_next;
  logic [ADDR_W-1:0] branch_next;
  logic [ADDR_W-1:0] operand_reg;
  logic [ADDR_W-1:0] branch_reg;

  // full 36-bit view of an accumulator, or sign-extended data register
  function automatic logic [ACC_W-1:0] data_to_acc(input logic [DATA_W-1:0] d);
    data_to_acc = {{EXT_W{d[DATA_W-1]}}, d, {DATA_W{1'b0}}};
  endfunction : data_to_acc

  function automatic logic [DATA_W-1:0] pick_data(input logic [1:0] f,
                                                  input logic [DATA_W-1:0] x,
                                                  input logic [DATA_W-1:0] yl,
                                                  input logic [DATA_W-1:0] yh);
    if (f == DD_X) begin
      pick_data = x;
    end else if (f == DD_Y_LOW) begin
      pick_data = yl;
    end else if (f == DD_Y_HIGH) begin
      pick_data = yh;
    end else begin
      pick_data = '0;
    end
  endfunction : pick_data

  // ---------------- operand read decode ----------------
  always_comb begin
    case (i_alu_operand_field)
      FDD_ACC_A:  o_alu_operand = accum_reg[0];
      FDD_ACC_B:  o_alu_operand = accum_reg[1];
      FDD_X, FDD_Y_LOW, FDD_Y_HIGH:
                  o_alu_operand = data_to_acc(pick_data(2'(i_alu_operand_field - FDD_X),
                                              data_reg[0], data_reg[1], data_reg[2]));
      default:    o_alu_operand = '0;
    endcase
    case (i_alu_upper_operand_field)
      FDD_ACC_A:  o_alu_upper_operand = accum_reg[0].upper_portion;
      FDD_ACC_B:  o_alu_upper_operand = accum_reg[1].upper_portion;
      FDD_X, FDD_Y_LOW, FDD_Y_HIGH:
                  o_alu_upper_operand = pick_data(2'(i_alu_upper_operand_field - FDD_X),
                                                  data_reg[0], data_reg[1], data_reg[2]);
      default:    o_alu_upper_operand = '0;
    endcase
    o_accum_operand       = accum_reg[i_accum_field];
    o_accum_upper_operand = accum_reg[i_accum_upper_field].upper_portion;
    o_data_reg_operand    = pick_data(i_data_reg_field, data_reg[0], data_reg[1], data_reg[2]);
  end

  // ---------------- accumulator and data register writes ----------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 2; k++) begin
        accum_reg[k] <= '{EXT_RESET, DATA_RESET, DATA_RESET};
      end
      for (int k = 0; k < 3; k++) begin
        data_reg[k] <= DATA_RESET;
      end
    end else begin
      case (i_wr_kind)
        WR_ACC_WHOLE: accum_reg[i_wr_sel[0]] <= i_wr_data;
        WR_ACC_EXT:   accum_reg[i_wr_sel[0]].extension_portion <= i_wr_data[EXT_W-1:0];
        WR_ACC_UPPER: accum_reg[i_wr_sel[0]].upper_portion <= i_wr_data[DATA_W-1:0];
        WR_ACC_LOWER: accum_reg[i_wr_sel[0]].lower_portion <= i_wr_data[DATA_W-1:0];
        WR_DATA: begin
          if (i_wr_sel[1:0] != 2'h3) begin
            data_reg[i_wr_sel[1:0]] <= i_wr_data[DATA_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------- effective address ----------------
  always_comb begin
    sel_ptr = (i_ea_req.ptr_sel == PSEL_SP) ? stack_ptr_reg
                                            : pointer_reg[i_ea_req.ptr_sel[1:0]];
    case (i_ea_req.mode)
      AM_IDX_OFS:  ea_next = sel_ptr + offset_reg;
      AM_IDX_DISP: ea_next = sel_ptr + i_ea_req.disp;
      default:     ea_next = sel_ptr;
    endcase
    case (i_ea_req.mode)
      AM_POST_INC: step = 16'h0001;
      AM_POST_DEC: step = 16'hffff;
      AM_POST_OFS: step = offset_reg;
      default:     step = 16'h0000;
    endcase
    do_update     = i_ea_req.valid && (step != 16'h0000);
    ea_valid_next = i_ea_req.valid;
    ea_prog_next  = i_ea_req.to_program;
    ea2_next      = pointer_reg[3];
    ea2_valid_next = i_ea_req2.valid;
    case (i_ea_req2.mode)
      AM_POST_INC: ptr2_next = pointer_reg[3] + 16'h0001;
      AM_POST_DEC: ptr2_next = pointer_reg[3] - 16'h0001;
      AM_POST_OFS: ptr2_next = pointer_reg[3] + offset_reg;
      default:     ptr2_next = pointer_reg[3];
    endcase
  end

  // modulo applies to pointer zero, and to pointer one when configured
  genvar g;
  generate
    for (g = 0; g <= NUM_PTR; g++) begin : g_upd
      if (g == 0) begin : g_mod0
        assign modulo_en[g] = (modifier_reg != MOD_LINEAR_CODE);
      end else if (g == 1) begin : g_mod1
        assign modulo_en[g] = MOD_COVERS_ONE && (modifier_reg != MOD_LINEAR_CODE);
      end else begin : g_lin
        assign modulo_en[g] = 1'b0;
      end
      pointer_update u_upd (
        .i_ptr         ((g == NUM_PTR) ? stack_ptr_reg : pointer_reg[g % NUM_PTR]),
        .i_step        (step),
        .i_modulo_en   (modulo_en[g]),
        .i_modulo_size (modifier_reg + 16'h0001),
        .o_ptr_next    (upd_result[g])
      );
    end
  endgenerate

  // pointer state: updated in the same cycle as the access
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < NUM_PTR; k++) begin
        pointer_reg[k] <= PTR_RESET;
      end
      stack_ptr_reg <= SP_RESET;
    end else begin
      if (i_wr_kind == WR_PTR && i_wr_sel != PSEL_SP) begin
        pointer_reg[i_wr_sel[1:0]] <= i_wr_data[ADDR_W-1:0];
      end else if (i_wr_kind == WR_PTR) begin
        stack_ptr_reg <= i_wr_data[ADDR_W-1:0];
      end
      if (do_update && i_ea_req.ptr_sel == PSEL_SP) begin
        stack_ptr_reg <= upd_result[NUM_PTR];
      end else if (do_update) begin
        pointer_reg[i_ea_req.ptr_sel[1:0]] <= upd_result[i_ea_req.ptr_sel[1:0]];
      end
      if (i_ea_req2.valid) begin
        pointer_reg[3] <= ptr2_next;
      end
    end
  end

  // offset and modifier registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      offset_reg   <= OFS_RESET;
      modifier_reg <= MOD_RESET;
    end else if (i_wr_kind == WR_AGU_CTRL) begin
      if (i_wr_sel[0]) begin
        modifier_reg <= i_wr_data[ADDR_W-1:0];
      end else begin
        offset_reg <= i_wr_data[ADDR_W-1:0];
      end
    end
  end

  // registered addresses toward the memory buses
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ea_reg        <= '0;
      ea_valid_reg  <= 1'b0;
      ea_prog_reg   <= 1'b0;
      ea2_reg       <= '0;
      ea2_valid_reg <= 1'b0;
    end else begin
      ea_reg        <= ea_next;
      ea_valid_reg  <= ea_valid_next;
      ea_prog_reg   <= ea_prog_next;
      ea2_reg       <= ea2_next;
      ea2_valid_reg <= ea2_valid_next;
    end
  end

  operand_extend u_ext (
    .i_ext_word      (i_ext_word),
    .i_instr         (i_instr),
    .i_kind          (i_operand_kind),
    .i_pc            (i_pc),
    .o_operand       (operand_next),
    .o_branch_target (branch_next)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      operand_reg <= '0;
      branch_reg  <= '0;
    end else begin
      operand_reg <= operand_next;
      branch_reg  <= branch_next;
    end
  end

  assign o_operand         = operand_reg;
  assign o_branch_target   = branch_reg;
  assign o_effective_addr  = ea_reg;
  assign o_addr_valid      = ea_valid_reg;
  assign o_addr_program    = ea_prog_reg;
  assign o_effective_addr2 = ea2_reg;
  assign o_addr2_valid     = ea2_valid_reg;
  assign o_pointer_zero    = pointer_reg[0];
  assign o_pointer_one     = pointer_reg[1];
  assign o_pointer_two     = pointer_reg[2];
  assign o_pointer_three   = pointer_reg[3];
  assign o_stack_ptr       = stack_ptr_reg;
  assign o_offset          = offset_reg;
  assign o_modifier_reg    = modifier_reg;

endmodule : dsp_operand_address_generation
`default_nettype wire

// file: testbench/mem_bus_model.sv
// data and program memory bus model that counts each access on the first address port and keeps the last address
`timescale 1ns/1ps
`default_nettype none
module mem_bus_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_valid,
  input  wire logic        i_program,
  output logic      [7:0]  o_x_count,
  output logic      [7:0]  o_p_count,
  output logic      [15:0] o_last_addr
);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_x_count   <= 8'h00;
      o_p_count   <= 8'h00;
      o_last_addr <= 16'h0000;
    end else if (i_valid) begin
      o_last_addr <= i_addr;
      if (i_program) begin
        o_p_count <= o_p_count + 8'h01;
      end else begin
        o_x_count <= o_x_count + 8'h01;
      end
    end
  end
endmodule : mem_bus_model
`default_nettype wire

// file: testbench/agu_checker_assertions.sv
// concurrent checks on operand widening and address generation outputs
`timescale 1ns/1ps
`default_nettype none
module agu_checker
  import agu_pkg::*;
(
  input wire logic             i_sys_clk,
  input wire logic             i_rst_n,
  input wire ea_req_type       i_ea_req,
  input wire ea_req_type       i_ea_req2,
  input wire logic      [15:0] i_instr,
  input wire logic      [15:0] i_ext_word,
  input wire operand_kind_type i_operand_kind,
  input wire logic      [15:0] i_pc,
  input wire logic      [15:0] o_operand,
  input wire logic      [15:0] o_branch_target,
  input wire logic      [15:0] o_effective_addr,
  input wire logic             o_addr_valid,
  input wire logic             o_addr_program,
  input wire logic      [15:0] o_effective_addr2,
  input wire logic             o_addr2_valid,
  input wire logic      [15:0] o_pointer_two,
  input wire logic      [15:0] o_pointer_three,
  input wire logic      [15:0] o_offset
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_addr_one_cycle: assert property (i_ea_req.valid |=> o_addr_valid && o_addr_program == $past(i_ea_req.to_program))
    else $error("address answer missing or wrong space");
  a_no_spurious_addr: assert property (!i_ea_req.valid |=> !o_addr_valid)
    else $error("address valid without request");
  a_abs_long_word: assert property (i_operand_kind == OP_ABS_LONG |=> o_operand == $past(i_ext_word))
    else $error("long address not taken from extension word");
  a_periph_ones_fill: assert property (i_operand_kind == OP_PERIPH_SHORT |=> o_operand == {10'h3ff, $past(i_instr[5:0])})
    else $error("peripheral short address not one-filled");
  a_abs_short_zero: assert property (i_operand_kind == OP_ABS_SHORT |=> o_operand == {10'h000, $past(i_instr[5:0])})
    else $error("absolute short address not zero-filled");
  a_imm_move_sign: assert property (i_operand_kind == OP_IMM_MOVE |=> o_operand == {{9{$past(i_instr[6])}}, $past(i_instr[6:0])})
    else $error("move immediate width wrong");
  a_branch_sum: assert property (1'b1 |=> o_branch_target == $past(i_pc) + {{9{$past(i_instr[6])}}, $past(i_instr[6:0])})
    else $error("branch target wrong");
  a_idx_disp_sum: assert property (i_ea_req.valid && i_ea_req.mode == AM_IDX_DISP && i_ea_req.ptr_sel == 3'h2
    |=> o_effective_addr == $past(o_pointer_two) + $past(i_ea_req.disp)) else $error("displacement address wrong");
  a_ptr_two_linear: assert property (i_ea_req.valid && i_ea_req.mode == AM_POST_INC && i_ea_req.ptr_sel == 3'h2
    |=> o_pointer_two == $past(o_pointer_two) + 16'h0001) else $error("pointer two not linear");
  a_post_offset_step: assert property (i_ea_req.valid && i_ea_req.mode == AM_POST_OFS && i_ea_req.ptr_sel == 3'h2
    |=> o_pointer_two == $past(o_pointer_two) + $past(o_offset)) else $error("offset post-update wrong");
  a_second_read_three: assert property (i_ea_req2.valid && i_ea_req2.mode == AM_POST_INC |=> o_addr2_valid &&
    o_effective_addr2 == $past(o_pointer_three) && o_pointer_three == $past(o_pointer_three) + 16'h0001)
    else $error("second read not from pointer three");

  c_dual_read: cover property (i_ea_req.valid && i_ea_req2.valid);
  c_periph: cover property (i_operand_kind == OP_PERIPH_SHORT);
  c_idx_ofs: cover property (i_ea_req.valid && i_ea_req.mode == AM_IDX_OFS);
endmodule : agu_checker
`default_nettype wire

// file: testbench/test_dsp_operand_address_generation.sv
// self-checking bench for operand decode and address generation
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin $display("BAD %s exp %h got %h", n, e, g); fail_count++; end end
module test_dsp_operand_address_generation;
  import agu_pkg::*;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_accum_field = 1'b0, i_accum_upper_field = 1'b0;
  logic [2:0] i_alu_operand_field = 3'h0, i_alu_upper_operand_field = 3'h0, i_wr_sel = 3'h0;
  logic [1:0] i_data_reg_field = 2'h0;
  logic [35:0] i_wr_data = 36'h0, o_alu_operand, o_accum_operand;
  logic [15:0] i_ext_word = 16'h0000, i_instr = 16'h0000, i_pc = 16'h0000;
  wr_kind_type i_wr_kind = WR_NONE;
  ea_req_type i_ea_req = '0, i_ea_req2 = '0;
  operand_kind_type i_operand_kind = OP_ABS_LONG;
  logic [15:0] o_alu_upper_operand, o_accum_upper_operand, o_data_reg_operand, o_operand, o_branch_target;
  logic [15:0] o_effective_addr, o_effective_addr2, o_pointer_zero, o_pointer_one, o_pointer_two;
  logic [15:0] o_pointer_three, o_stack_ptr, o_offset, o_modifier_reg, last_addr;
  logic o_addr_valid, o_addr_program, o_addr2_valid;
  logic [7:0] x_cnt, p_cnt;
  int fail_count = 0, tests_run = 0, cyc = 0;

  dsp_operand_address_generation dut (.*);
  mem_bus_model u_mem (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(o_effective_addr),
    .i_valid(o_addr_valid), .i_program(o_addr_program), .o_x_count(x_cnt), .o_p_count(p_cnt),
    .o_last_addr(last_addr));

  always #5 i_sys_clk = ~i_sys_clk;

  function automatic ea_req_type rq(addr_mode_type m, logic [2:0] s, logic p, logic [15:0] d);
    rq = '{1'b1, m, s, p, d};
  endfunction : rq

  task automatic wr(input wr_kind_type k, input logic [2:0] s, input logic [35:0] d);
    @(posedge i_sys_clk);
    i_wr_kind <= k;
    i_wr_sel <= s;
    i_wr_data <= d;
    @(posedge i_sys_clk);
    i_wr_kind <= WR_NONE;
  endtask : wr

  task automatic ea(input ea_req_type r, input ea_req_type r2);
    @(posedge i_sys_clk);
    i_ea_req <= r;
    i_ea_req2 <= r2;
    @(posedge i_sys_clk);
    i_ea_req <= '0;
    i_ea_req2 <= '0;
    #1;
  endtask : ea

  task automatic t_regs;
    logic [2:0] code[6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [35:0] ae[6] = '{36'h9_1234_5678, 36'h3_abcd_0042, 36'hf_8001_0000, 36'h0_1234_0000, 36'h0_7fff_0000, 36'h0};
    logic [15:0] ue[6] = '{16'h1234, 16'habcd, 16'h8001, 16'h1234, 16'h7fff, 16'h0000};
    wr(WR_ACC_WHOLE, 3'h0, 36'h9_1234_5678);
    wr(WR_ACC_EXT, 3'h1, 36'h3);
    wr(WR_ACC_UPPER, 3'h1, 36'habcd);
    wr(WR_ACC_LOWER, 3'h1, 36'h42);
    for (int i = 0; i < 4; i++) wr(WR_DATA, i[2:0], {20'h0, ue[i + 2]} | 36'h5555 * (i == 3));
    for (int i = 0; i < 6; i++) begin
      @(posedge i_sys_clk);
      i_alu_operand_field <= code[i];
      i_alu_upper_operand_field <= code[i];
      i_accum_field <= i[0];
      i_accum_upper_field <= i[0];
      i_data_reg_field <= i[1:0];
      #1;
      `CHK("alu operand", ae[i], o_alu_operand)
      `CHK("alu upper", ue[i], o_alu_upper_operand)
      `CHK("accum", ae[i[0]], o_accum_operand)
      `CHK("accum upper", ue[i[0]], o_accum_upper_operand)
      `CHK("data reg", (i % 4 == 3) ? 16'h0000 : ue[(i % 4) + 2], o_data_reg_operand)
    end
    $display("register field test done");
  endtask : t_regs

  task automatic t_operands;
    logic [15:0] oe[7] = '{16'hbeef, 16'hffe5, 16'h0025, 16'hffe5, 16'h0025, 16'he500, 16'h00e5};
    @(posedge i_sys_clk);
    i_instr <= 16'h00e5;
    i_ext_word <= 16'hbeef;
    i_pc <= 16'h0100;
    for (int k = 0; k < 7; k++) begin
      @(posedge i_sys_clk);
      i_operand_kind <= operand_kind_type'(k[2:0]);
      @(posedge i_sys_clk);
      #1;
      `CHK("operand", oe[k], o_operand)
    end
    `CHK("branch", 16'h00e5, o_branch_target)
    $display("operand test done");
  endtask : t_operands

  task automatic t_addr;
    wr(WR_PTR, 3'h1, 36'h5);
    wr(WR_PTR, 3'h2, 36'h7);
    wr(WR_PTR, 3'h3, 36'h40);
    wr(WR_PTR, 3'h4, 36'h200);
    wr(WR_AGU_CTRL, 3'h0, 36'h3);
    ea(rq(AM_POST_NONE, 3'h4, 1'b1, 16'h0000), '0);
    `CHK("sp addr", 16'h0200, o_effective_addr)
    `CHK("program", 1'b1, o_addr_program)
    ea(rq(AM_IDX_OFS, 3'h1, 1'b0, 16'h0000), '0);
    `CHK("idx ofs", 16'h0008, o_effective_addr)
    `CHK("idx keeps ptr", 16'h0005, o_pointer_one)
    ea(rq(AM_IDX_DISP, 3'h2, 1'b0, 16'h0100), '0);
    `CHK("idx disp", 16'h0107, o_effective_addr)
    ea(rq(AM_POST_OFS, 3'h2, 1'b0, 16'h0000), '0);
    `CHK("post ofs addr", 16'h0007, o_effective_addr)
    `CHK("post ofs ptr", 16'h000a, o_pointer_two)
    ea(rq(AM_POST_DEC, 3'h3, 1'b0, 16'h0000), '0);
    `CHK("post dec", 16'h003f, o_pointer_three)
    ea(rq(AM_POST_INC, 3'h1, 1'b0, 16'h0000), rq(AM_POST_INC, 3'h0, 1'b0, 16'h0000));
    `CHK("dual first", 16'h0005, o_effective_addr)
    `CHK("dual second", 16'h003f, o_effective_addr2)
    `CHK("dual valid", 1'b1, o_addr2_valid)
    `CHK("ptr one linear", 16'h0006, o_pointer_one)
    `CHK("sp kept", 16'h0200, o_stack_ptr)
    `CHK("offset", 16'h0003, o_offset)
    // the model logs the dual read's address one edge after it is issued
    @(posedge i_sys_clk);
    #1;
    `CHK("x accesses", 8'h05, x_cnt)
    `CHK("p accesses", 8'h01, p_cnt)
    $display("address test done");
  endtask : t_addr

  task automatic t_modulo;
    wr(WR_AGU_CTRL, 3'h1, 36'h7);
    for (int i = 0; i < 4; i++) wr(WR_PTR, i[2:0], 36'h7);
    `CHK("modifier", 16'h0007, o_modifier_reg)
    ea(rq(AM_POST_INC, 3'h0, 1'b0, 16'h0000), '0);
    `CHK("ptr zero wrap", 16'h0000, o_pointer_zero)
    ea(rq(AM_POST_INC, 3'h1, 1'b0, 16'h0000), rq(AM_POST_INC, 3'h0, 1'b0, 16'h0000));
    `CHK("ptr one wrap", 16'h0000, o_pointer_one)
    `CHK("ptr three linear", 16'h0008, o_pointer_three)
    ea(rq(AM_POST_INC, 3'h2, 1'b0, 16'h0000), '0);
    `CHK("ptr two linear", 16'h0008, o_pointer_two)
    $display("modulo test done");
  endtask : t_modulo

  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      $display("timeout reached");
      close_out;
    end
  end

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    `CHK("modifier reset", 16'hffff, o_modifier_reg)
    `CHK("ptr reset", 16'h0000, o_pointer_zero)
    `CHK("valid reset", 1'b0, o_addr_valid)
    $display("reset test done");
    t_regs;
    t_operands;
    t_addr;
    t_modulo;
    close_out;
  end
endmodule : test_dsp_operand_address_generation
bind dsp_operand_address_generation agu_checker u_chk (.*);
`default_nettype wire
